// ==== hdl/ltmc_pkg.sv ====
// package: constants and types of the logic timing and mode control block
package ltmc_pkg;
  // ==========================================
  // clocking
  // ==========================================
  localparam int MCLK_PERIOD_NS = 10; // 100 mhz system clock
  localparam int LOGIC_PERIOD_NS = 1000; // one logic clock period, 1 us
  localparam int PERIOD_CYC = LOGIC_PERIOD_NS / MCLK_PERIOD_NS;
  localparam logic [7:0] PHASE_LAST = 8'(PERIOD_CYC - 1);
  // slave stage locked window, master unlocked inside it (overlap both sides)
  localparam logic [7:0] SLAVE_LOCK_BEGIN = 8'h1e;
  localparam logic [7:0] SLAVE_LOCK_END = 8'h45;
  localparam logic [7:0] MASTER_OPEN_BEGIN = 8'h28;
  localparam logic [7:0] MASTER_OPEN_END = 8'h3b;
  // ==========================================
  // reference timer
  // ==========================================
  localparam int NUM_DECADES = 6; // six fixed-rate pulses
  localparam logic [3:0] DECADE_LAST = 4'h9;
  // ==========================================
  // register map (byte addresses)
  // ==========================================
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] THUMB_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] COUNT_OFS = 8'h0c;
  // ctrl fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_TEN_BIT = 2;
  localparam int CTRL_HUNDRED_BIT = 3;
  localparam int CTRL_HANDOFF_BIT = 4;
  localparam int CTRL_SIMUL_BIT = 5;
  localparam int CTRL_SEL_LSB = 6;
  localparam int CTRL_ABTN_LSB = 8;
  localparam logic [9:0] CTRL_RESET = 10'h000;
  localparam logic [23:0] THUMB_RESET = 24'h000000;
  // ==========================================
  // modes and states
  // ==========================================
  typedef enum logic [1:0] {
    LM_LOAD = 2'b00,
    LM_RUN = 2'b01,
    LM_STOP = 2'b10
  } ltmc_lmode_e;
  typedef enum logic [1:0] {
    IT_A = 2'b00,
    IT_B = 2'b01,
    IT_C = 2'b10
  } ltmc_itstate_e;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_STEP = 2'b01,
    ST_BURST = 2'b10
  } ltmc_step_e;
endpackage

// ==== hdl/ltmc_pulse_if.sv ====
// interface: enabled-period tick to the reference timer, fixed pulses back
`timescale 1ns/1ns
interface ltmc_pulse_if;
  import ltmc_pkg::*;
  logic tick; // one enabled logic period has completed
  logic [NUM_DECADES:0] fixed; // bit0 logic one, bit k = 10^k us rate
  modport timer (input tick, output fixed);
  modport user (output tick, input fixed);
endinterface

// ==== hdl/ltmc_ref_timer.sv ====
// module: decade reference timer producing the fixed-rate pulses
`timescale 1ns/1ns
module ltmc_ref_timer
  import ltmc_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  ltmc_pulse_if.timer pif
);
  // ==========================================
  // decade counters
  // ==========================================
  logic [3:0] digit [NUM_DECADES]; // one decade per fixed pulse
  logic [NUM_DECADES:0] carry; // carry[k]: decades below k all at zero
  assign carry[0] = 1'b1;
  genvar k;
  generate
    for (k = 0; k < NUM_DECADES; k++) begin : g_dec
      assign carry[k+1] = carry[k] && (digit[k] == 4'h0);
      // a decade only moves when every lower one stands at zero, so rates are exact
      always_ff @(posedge mclk) begin
        if (!rstn) begin
          digit[k] <= 4'h0;
        end else if (pif.tick && carry[k]) begin
          digit[k] <= (digit[k] == DECADE_LAST) ? 4'h0 : digit[k] + 4'h1;
        end
      end
    end
  endgenerate
  // ==========================================
  // pulse outputs
  // ==========================================
  // pulses are levels held for a whole logic period, the digits only move
  // at period boundaries; bit0 is the constant logic one
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      pif.fixed <= '0;
    end else begin
      pif.fixed <= {carry[NUM_DECADES:1] & {NUM_DECADES{1'b1}}, 1'b1};
    end
  end
endmodule

// ==== hdl/ltmc_top.sv ====
// module: two-phase logic clock, time scaling, interval timer, mode buses
`timescale 1ns/1ns
module ltmc_top
  import ltmc_pkg::*;
#(
  parameter int THUMB_W = 8 // width of each thumbwheel count
)(
  input wire logic mclk,
  input wire logic rstn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // panel and patchboard
  input wire logic advance_button,
  input wire logic burst_step_input,
  // logic clock and fixed / scaled pulses
  output logic master_phase_clock,
  output logic slave_phase_clock,
  output logic load_bus,
  output logic [NUM_DECADES:0] fixed_pulse,
  output logic [3:0] scaled_pulse,
  // interval timer and analog mode buses
  output logic [2:0] timer_state_abc,
  output logic initial_condition_mode,
  output logic operate_mode,
  output logic hold_mode,
  output logic master_hold
);
  // ==========================================
  // decode functions
  // ==========================================
  // scale shift in decades from the two buttons
  function automatic logic [1:0] scale_shift(input logic ten, input logic hundred);
    return {hundred, ten};
  endfunction
  // one-hot analog mode {hold, operate, ic} from a 2-bit mode code
  function automatic logic [2:0] mode_onehot(input logic [1:0] m);
    logic [2:0] r;
    r = 3'b001;
    case (m)
      2'b00: r = 3'b001;
      2'b01: r = 3'b010;
      2'b10: r = 3'b100;
      default: r = 3'b100; // undefined code parks in hold
    endcase
    return r;
  endfunction
  // ==========================================
  // control registers
  // ==========================================
  logic [9:0] ctrl; // panel settings
  logic [3*THUMB_W-1:0] thumb; // thumbwheels A, B, C
  ltmc_lmode_e lmode;
  logic [1:0] shift;
  assign lmode = ltmc_lmode_e'(ctrl[CTRL_MODE_LSB +: 2]);
  assign shift = scale_shift(ctrl[CTRL_TEN_BIT], ctrl[CTRL_HUNDRED_BIT]);
  // ==========================================
  // ahb-lite address and data phase
  // ==========================================
  logic wr_pend; // data phase of a write is due
  logic [7:0] wr_ofs; // its register offset
  logic take; // address phase accepted this edge
  assign take = hsel && htrans[1] && hready;
  // capture the address phase; the slave never inserts waits
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      wr_pend <= 1'b0;
      wr_ofs <= 8'h00;
    end else begin
      wr_pend <= take && hwrite;
      wr_ofs <= haddr[7:0];
    end
  end
  // response is fixed: always ready, always okay
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end
  // register writes in the data phase; unmapped offsets are ignored
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      ctrl <= CTRL_RESET;
      thumb <= THUMB_RESET[3*THUMB_W-1:0];
    end else if (wr_pend) begin
      case (wr_ofs)
        CTRL_OFS: ctrl <= hwdata[9:0];
        THUMB_OFS: thumb <= hwdata[3*THUMB_W-1:0];
        default: ;
      endcase
    end
  end
  // ==========================================
  // advance button synchroniser and edge
  // ==========================================
  logic btn_s1; // first stage, read only by btn_s2
  logic btn_s2;
  logic btn_s3;
  logic press; // one cycle per press
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      btn_s1 <= 1'b0;
      btn_s2 <= 1'b0;
      btn_s3 <= 1'b0;
    end else begin
      btn_s1 <= advance_button;
      btn_s2 <= btn_s1;
      btn_s3 <= btn_s2;
    end
  end
  assign press = btn_s2 && !btn_s3;
  // ==========================================
  // logic clock period and stepping
  // ==========================================
  logic [7:0] phase; // position inside the 1 us period
  logic period_end;
  ltmc_step_e step_st; // stepping request
  logic run_period; // clocks run in the current period
  logic next_run;
  assign period_end = (phase == PHASE_LAST);
  // free-running divider so every period is exactly 1 us long
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      phase <= 8'h00;
    end else begin
      phase <= period_end ? 8'h00 : phase + 8'h01;
    end
  end
  // press in stop arms a single step, or a burst when the burst input is up;
  // a press while a step is armed or bursting is absorbed
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      step_st <= ST_IDLE;
    end else if (lmode != LM_STOP) begin
      step_st <= ST_IDLE; // stepping only acts in stop
    end else begin
      case (step_st)
        ST_IDLE: begin
          if (press) begin
            step_st <= burst_step_input ? ST_BURST : ST_STEP;
          end
        end
        ST_STEP: begin
          if (period_end) begin
            step_st <= ST_IDLE; // its one period now starts
          end
        end
        ST_BURST: begin
          if (period_end && !burst_step_input) begin
            step_st <= ST_IDLE;
          end
        end
        default: step_st <= ST_IDLE;
      endcase
    end
  end
  // decide at each boundary whether the coming period is clocked
  always_comb begin
    next_run = 1'b0;
    case (lmode)
      LM_RUN: next_run = 1'b1;
      LM_STOP: next_run = (step_st == ST_STEP) ||
        ((step_st == ST_BURST) && burst_step_input);
      default: next_run = 1'b0;
    endcase
  end
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      run_period <= 1'b0;
    end else if (period_end) begin
      run_period <= next_run;
    end
  end
  // two-phase waveforms; the slave locks before the master opens and the
  // master closes before the slave reopens, so no stage races its input
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      master_phase_clock <= 1'b1;
      slave_phase_clock <= 1'b0;
    end else if (run_period) begin
      master_phase_clock <= !(phase >= MASTER_OPEN_BEGIN && phase <= MASTER_OPEN_END);
      slave_phase_clock <= (phase >= SLAVE_LOCK_BEGIN && phase <= SLAVE_LOCK_END);
    end else begin
      master_phase_clock <= 1'b1;
      slave_phase_clock <= 1'b0;
    end
  end
  // load bus forces devices to their load state
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      load_bus <= 1'b1;
    end else begin
      load_bus <= (lmode == LM_LOAD);
    end
  end
  // ==========================================
  // reference timer and time scale selector
  // ==========================================
  ltmc_pulse_if pif ();
  logic tick; // one clocked period just ended
  assign tick = period_end && run_period;
  assign pif.tick = tick;
  ltmc_ref_timer u_ref (
    .mclk(mclk),
    .rstn(rstn),
    .pif(pif.user)
  );
  // fixed pulses pass through untouched by the scale buttons
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      fixed_pulse <= '0;
    end else begin
      fixed_pulse <= pif.fixed;
    end
  end
  // scaled pulse j (1 ms .. 1 s) takes the fixed pulse shift decades faster;
  // at 1000x the 1 ms pulse lands on bit0, the constant logic one
  genvar j;
  generate
    for (j = 0; j < 4; j++) begin : g_scaled
      always_ff @(posedge mclk) begin
        if (!rstn) begin
          scaled_pulse[j] <= 1'b0;
        end else begin
          scaled_pulse[j] <= pif.fixed[3'(j + 3) - 3'(shift)];
        end
      end
    end
  endgenerate
  // ==========================================
  // interval timer
  // ==========================================
  ltmc_itstate_e it_st; // current interval state
  logic [THUMB_W-1:0] it_cnt; // scaled pulses counted in this state
  logic [THUMB_W-1:0] it_lim; // thumbwheel for this state
  logic sel_pulse; // chosen scaled pulse
  always_comb begin
    it_lim = thumb[THUMB_W-1:0];
    case (it_st)
      IT_A: it_lim = thumb[THUMB_W-1:0];
      IT_B: it_lim = thumb[2*THUMB_W-1:THUMB_W];
      IT_C: it_lim = thumb[3*THUMB_W-1:2*THUMB_W];
      default: it_lim = thumb[THUMB_W-1:0];
    endcase
  end
  // the counted pulse is sampled from the reference timer directly so it
  // lines up with the period that ends on this tick
  assign sel_pulse = pif.fixed[3'(ctrl[CTRL_SEL_LSB +: 2]) + 3'd3 - 3'(shift)];
  // a zero thumbwheel still spends one pulse in its state
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      it_st <= IT_A;
      it_cnt <= '0;
    end else if (lmode == LM_LOAD) begin
      it_st <= IT_A;
      it_cnt <= '0;
    end else if (lmode == LM_RUN && tick && sel_pulse) begin
      if (it_cnt + 1'b1 >= it_lim) begin
        it_cnt <= '0;
        case (it_st)
          IT_A: it_st <= IT_B;
          IT_B: it_st <= IT_C;
          IT_C: it_st <= IT_A;
          default: it_st <= IT_A;
        endcase
      end else begin
        it_cnt <= it_cnt + 1'b1;
      end
    end
  end
  // ==========================================
  // analog mode buses
  // ==========================================
  logic [2:0] next_amode; // {hold, operate, ic}
  always_comb begin
    if (ctrl[CTRL_HANDOFF_BIT]) begin
      next_amode = mode_onehot(it_st);
    end else if (ctrl[CTRL_SIMUL_BIT]) begin
      next_amode = mode_onehot(lmode);
    end else begin
      next_amode = mode_onehot(ctrl[CTRL_ABTN_LSB +: 2]);
    end
  end
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      initial_condition_mode <= 1'b1;
      operate_mode <= 1'b0;
      hold_mode <= 1'b0;
      master_hold <= 1'b0;
      timer_state_abc <= 3'b001;
    end else begin
      initial_condition_mode <= next_amode[0];
      operate_mode <= next_amode[1];
      hold_mode <= next_amode[2];
      // stops analog with logic so a stop in B cannot run away
      master_hold <= ctrl[CTRL_HANDOFF_BIT] && (lmode == LM_STOP);
      timer_state_abc <= mode_onehot(it_st);
    end
  end
  // ==========================================
  // read mux
  // ==========================================
  logic [31:0] rd_val;
  always_comb begin
    rd_val = 32'h0000_0000;
    case (haddr[7:0])
      CTRL_OFS: rd_val = {22'h000000, ctrl};
      THUMB_OFS: rd_val = {{(32-3*THUMB_W){1'b0}}, thumb};
      STATUS_OFS: rd_val = {12'h000, master_hold, hold_mode, operate_mode,
        initial_condition_mode, scaled_pulse, fixed_pulse, step_st,
        run_period, it_st};
      COUNT_OFS: rd_val = {{(32-THUMB_W){1'b0}}, it_cnt};
      default: rd_val = 32'h0000_0000;
    endcase
  end
  // read data is captured at the address phase and stands in the data phase
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      hrdata <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      hrdata <= rd_val;
    end
  end
endmodule

// ==== bench/ltmc_timing_props.sv ====
// checker: timing and mode relations seen at the block's ports
`timescale 1ns/1ns
module ltmc_timing_props
  import ltmc_pkg::*;
#(
  parameter int THUMB_W = 8
)(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic master_phase_clock,
  input wire logic slave_phase_clock,
  input wire logic load_bus,
  input wire logic [NUM_DECADES:0] fixed_pulse,
  input wire logic [2:0] timer_state_abc,
  input wire logic initial_condition_mode,
  input wire logic operate_mode,
  input wire logic hold_mode,
  input wire logic master_hold
);
  // ==========================================
  // helper logic
  // ==========================================
  logic wr_ctrl; // ctrl write now in its data phase
  logic [9:0] ctrl_s; // shadow of the ctrl register
  logic [7:0] age; // cycles since the last ctrl write
  logic [7:0] hi_cnt; // high run of the ten-period pulse
  logic [7:0] lo_cnt; // master unlocked run
  logic [7:0] sh_cnt; // slave locked run
  logic settled; // a mode change may need a whole period to land
  logic [2:0] amode; // analog mode buses, hold down to ic
  assign settled = age > 8'h6e;
  assign amode = {hold_mode, operate_mode, initial_condition_mode};
  // bus snoop keeps the ctrl shadow and its age
  always_ff @(posedge mclk) begin
    wr_ctrl <= rstn && hsel && htrans[1] && hready && hwrite && haddr[7:0] == CTRL_OFS;
    if (!rstn) ctrl_s <= CTRL_RESET;
    else if (wr_ctrl) ctrl_s <= hwdata[9:0];
    if (!rstn || wr_ctrl) age <= 8'h0;
    else if (age != 8'hff) age <= age + 8'h1;
  end
  // run lengths; hi_cnt saturates since stop freezes the pulse
  always_ff @(posedge mclk) begin
    hi_cnt <= (!rstn || !fixed_pulse[1]) ? 8'h0 : hi_cnt + {7'h0, hi_cnt != 8'hff};
    lo_cnt <= (!rstn || master_phase_clock) ? 8'h0 : lo_cnt + 8'h1;
    sh_cnt <= (!rstn || !slave_phase_clock) ? 8'h0 : sh_cnt + 8'h1;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // ==========================================
  // assertions
  // ==========================================
  bus_okay_a:
    assert property (hreadyout && !hresp) else $error("bus answer not ready or not okay");
  // the pulse path is two flops deep, so bit0 only shows up two edges after reset
  fixed_one_a:
    assert property ($past(rstn, 2) |-> fixed_pulse[0]) else $error("logic one pulse dropped");
  fixed_width_a:
    assert property ($fell(fixed_pulse[1]) && settled && ctrl_s[1:0] == LM_RUN
      |-> hi_cnt >= 8'h64) else $error("fixed pulse shorter than a period");
  master_open_a:
    assert property ($rose(master_phase_clock) |-> lo_cnt == 8'h14)
      else $error("master open window length wrong");
  slave_lock_a:
    assert property ($fell(slave_phase_clock) |-> sh_cnt == 8'h28)
      else $error("slave lock window length wrong");
  phase_overlap_a:
    assert property (!master_phase_clock |-> slave_phase_clock)
      else $error("master open while slave unlocked");
  load_reset_a:
    assert property (settled && ctrl_s[1:0] == LM_LOAD
      |-> timer_state_abc == 3'h1 && master_phase_clock && load_bus)
      else $error("load did not reset timer or lock clocks");
  master_hold_a:
    assert property (settled |-> master_hold == (ctrl_s[4] && ctrl_s[1:0] == LM_STOP))
      else $error("master hold wrong");
  exec_map_a:
    assert property (settled && ctrl_s[4] && ctrl_s[1:0] == LM_RUN && $stable(timer_state_abc)
      |-> amode == timer_state_abc) else $error("analog mode not following timer");
  simul_map_a:
    assert property (settled && ctrl_s[5:4] == 2'h2 |-> amode == 3'h1 << ctrl_s[1:0])
      else $error("analog mode not tracking logic mode");
endmodule
bind ltmc_top ltmc_timing_props #(.THUMB_W(THUMB_W)) chk_u (
  .mclk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp,
  .master_phase_clock, .slave_phase_clock, .load_bus, .fixed_pulse, .timer_state_abc,
  .initial_condition_mode, .operate_mode, .hold_mode, .master_hold
);

// ==== bench/ltmc_patch_model.sv ====
// partner: patched user logic pressing advance and holding burst for n periods
`timescale 1ns/1ns
module ltmc_patch_model (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic slave_phase_clock,
  input wire logic go, // start one press
  input wire logic [7:0] burst_len, // periods wanted, 0 for a single step
  input wire logic [9:0] press_len, // button hold in cycles, one less than the cycles it stays down
  output logic advance_button,
  output logic burst_step_input,
  output logic busy
);
  logic [9:0] press_cnt; // remaining button hold
  logic [7:0] left; // periods still to let through
  logic slave_d; // slave phase one cycle back, to see it fall
  assign busy = advance_button || burst_step_input;
  // ==========================================
  // button and burst counter
  // ==========================================
  always_ff @(posedge mclk) begin
    slave_d <= slave_phase_clock;
    if (!rstn) begin
      advance_button <= 1'h0;
      burst_step_input <= 1'h0;
      press_cnt <= 10'h0;
      left <= 8'h0;
    end else if (go && !busy) begin
      advance_button <= 1'h1;
      press_cnt <= press_len;
      left <= burst_len;
      burst_step_input <= burst_len != 8'h0;
    end else begin
      // a long hold must still give only one press
      if (press_cnt != 10'h0) press_cnt <= press_cnt - 10'h1;
      else advance_button <= 1'h0;
      // drop burst at the slave fall of the last wanted period, well before its boundary
      if (slave_d && !slave_phase_clock && left != 8'h0) begin
        left <= left - 8'h1;
        if (left == 8'h1) burst_step_input <= 1'h0;
      end
    end
  end
endmodule

// ==== bench/ltmc_bench.sv ====
// testbench: drives the timing and mode block and judges its ports
`timescale 1ns/1ns
module ltmc_bench
  import ltmc_pkg::*;
;
  logic mclk, rstn, hsel, hwrite, go, busy, adv, burst;
  logic hreadyout, hresp, mpc, spc, load_bus, icm, opm, hlm, mhold;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize, tst;
  logic [NUM_DECADES:0] fix;
  logic [3:0] scl;
  logic [7:0] blen;
  logic [9:0] plen;
  int bad_count, total_checks, per_cnt;
  ltmc_top dut_u (.mclk(mclk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .advance_button(adv),
    .burst_step_input(burst), .master_phase_clock(mpc), .slave_phase_clock(spc),
    .load_bus(load_bus), .fixed_pulse(fix), .scaled_pulse(scl), .timer_state_abc(tst),
    .initial_condition_mode(icm), .operate_mode(opm), .hold_mode(hlm), .master_hold(mhold));
  ltmc_patch_model patch_u (.mclk(mclk), .rstn(rstn), .slave_phase_clock(spc), .go(go),
    .burst_len(blen), .press_len(plen), .advance_button(adv), .burst_step_input(burst),
    .busy(busy));
  // ==========================================
  // clock, watchdog, period counter
  // ==========================================
  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    #1000000;
    bad_count++;
    conclude();
  end
  always @(negedge mpc) per_cnt++;
  // ==========================================
  // shared tasks
  // ==========================================
  task automatic conclude;
    if (bad_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // bounded wait for ready at a rising edge
  task automatic rdy;
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (hreadyout !== 1'h1 && n < 20);
    if (n >= 20) begin
      bad_count++;
      conclude();
    end
  endtask
  // one single-word transfer: address phase, then data phase
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
      output logic [31:0] q);
    @(posedge mclk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    rdy();
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    q = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'h1, a, d, q);
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] q);
    bus(1'h0, a, 32'h0, q);
  endtask
  task automatic mode(input logic [9:0] c);
    wr(32'(CTRL_OFS), {22'h0, c});
  endtask
  // land mid-period, away from the tick, by waiting for master to open
  task automatic mid;
    int t;
    t = 0;
    do begin
      cyc(1);
      t++;
    end while (mpc !== 1'h0 && t < 200);
    if (t >= 200) begin
      bad_count++;
      conclude();
    end
  endtask
  // one press through the partner, then let the last period finish
  task automatic press(input logic [7:0] n, input logic [9:0] len);
    int t;
    @(posedge mclk);
    blen <= n;
    plen <= len;
    go <= 1'h1;
    @(posedge mclk);
    go <= 1'h0;
    t = 0;
    do begin
      cyc(1);
      t++;
    end while (busy !== 1'h0 && t < 2000);
    if (t >= 2000) begin
      bad_count++;
      conclude();
    end
    cyc(250);
  endtask
  // ==========================================
  // scenarios
  // ==========================================
  task automatic t_reset;
    repeat (16) @(posedge mclk);
    #1;
    chk("reset", {mpc, spc, load_bus, tst, icm, opm, hlm, mhold}, 32'h298);
    @(posedge mclk);
    rstn <= 1'h1;
  endtask
  task automatic t_regs;
    logic [31:0] q;
    wr(32'(CTRL_OFS), 32'hffff_fe35);
    rd(32'(CTRL_OFS), q);
    chk("ctrl", q, 32'h235);
    wr(32'(THUMB_OFS), 32'hdead_5a3c);
    rd(32'(THUMB_OFS), q);
    chk("thumb", q, 32'had_5a3c);
    wr(32'h10, 32'hffff_ffff);
    rd(32'h10, q);
    chk("unmapped", q, 32'h0);
  endtask
  task automatic t_scale;
    int hits;
    for (int s = 0; s < 4; s++) begin
      hits = 0;
      mode(10'h1 | 10'(s << 2));
      cyc(250);
      mid();
      for (int i = 0; i < 30; i++) begin
        cyc(100);
        hits += int'(fix[1] === 1'h1);
        chk("logic_one", fix[0], 1'h1);
        for (int j = 0; j < 4; j++)
          chk("scaled", scl[j], fix[j + 3 - s]);
      end
      chk("fixed_rate", hits, 3);
    end
  endtask
  task automatic t_timer;
    int k;
    int n[3];
    logic [31:0] q;
    wr(32'(THUMB_OFS), 32'h0001_0302);
    for (int sel = 0; sel < 2; sel++) begin
      k = (sel == 0) ? 1 : 10;
      n = '{0, 0, 0};
      mode(10'h0);
      cyc(150);
      chk("load_state", tst, 3'h1);
      rd(32'(STATUS_OFS), q);
      chk("load_status", q & 32'h000f_001f, 32'h0001_0000);
      rd(32'(COUNT_OFS), q);
      chk("load_count", q, 32'h0);
      // analog buttons ask for hold; handoff must override them
      mode(10'h21d | 10'(sel << 6));
      cyc(1000 * k + 50);
      mid();
      for (int i = 0; i < 12 * k; i++) begin
        cyc(100);
        for (int b = 0; b < 3; b++)
          n[b] += int'(tst[b] === 1'h1);
        chk("exec_mode", {hlm, opm, icm}, tst);
      end
      chk("state_a", n[0], 4 * k);
      chk("state_b", n[1], 6 * k);
      chk("state_c", n[2], 2 * k);
    end
  endtask
  task automatic t_stop;
    int p;
    mode(10'h12);
    cyc(150);
    chk("hold_on", mhold, 1'h1);
    p = per_cnt;
    cyc(300);
    chk("stopped", per_cnt, p);
    press(8'h0, 10'h1f4);
    chk("step", per_cnt, p + 1);
    press(8'h5, 10'h14);
    chk("burst", per_cnt, p + 6);
    mode(10'h0);
    press(8'h0, 10'h14);
    chk("load_step", per_cnt, p + 6);
    // handoff off: the analog buttons own the mode buses again
    mode(10'h202);
    cyc(150);
    chk("hold_off", mhold, 1'h0);
    chk("buttons", {hlm, opm, icm}, 3'h4);
  endtask
  task automatic t_simul;
    for (int m = 0; m < 3; m++) begin
      mode(10'h20 | 10'(m));
      cyc(150);
      chk("simul", {hlm, opm, icm}, 3'h1 << m);
    end
  endtask
  // ==========================================
  // main sequence
  // ==========================================
  initial begin
    rstn = 1'h0;
    hsel = 1'h0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
    go = 1'h0;
    blen = 8'h0;
    plen = 10'h0;
    bad_count = 0;
    total_checks = 0;
    per_cnt = 0;
    t_reset();
    t_regs();
    t_scale();
    t_timer();
    t_stop();
    t_simul();
    conclude();
  end
endmodule
